// file: design/toio_map.svh
`ifndef TOIO_MAP_SVH
`define TOIO_MAP_SVH
`define TOIO_SYNC_RST 3'h7
`define TOIO_SYNC_IDLE 1'b1
`define TOIO_DEB_RST 16'h0000
`define TOIO_DEB_TIME_US 1000
`define TOIO_CLK_MHZ 250
`define TOIO_PRESS_W 32
`endif

// file: design/toio_pkg.sv
package toio_pkg;
	typedef enum logic [2:0]
	{
		TOIO_IDLE = 3'h1,
		TOIO_PRESSED = 3'h2,
		TOIO_RELEASE = 3'h4
	} toio_key_t;
endpackage

// file: design/toio_sync.sv
`include "toio_map.svh"
// Three-stage synchroniser; output changes only once stages two and three agree
module toio_sync
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic async_i,
	output logic sync_o
);
	typedef struct packed
	{
		logic [2:0] stage;
		logic level;
	} toio_sync_state_t;

	toio_sync_state_t cur_r;
	toio_sync_state_t cur_nxt;

	// Stage one is read only by stage two
	always_comb
	begin
		cur_nxt = cur_r;
		cur_nxt.stage = {cur_r.stage[1:0], async_i};
		if (cur_r.stage[1] == cur_r.stage[2])
		begin
			cur_nxt.level = cur_r.stage[2];
		end
	end

	// Idle level of the input is high (pulled up, closure to ground)
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cur_r <= '{stage: `TOIO_SYNC_RST, level: `TOIO_SYNC_IDLE};
		end
		else
		begin
			cur_r <= cur_nxt;
		end
	end

	assign sync_o = cur_r.level;
endmodule

// file: design/toio_top.sv
`include "toio_map.svh"
module toio_top
#(
	parameter int PRESS_W = `TOIO_PRESS_W,
	parameter int DEB_CYCLES = `TOIO_DEB_TIME_US * `TOIO_CLK_MHZ
)
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic tare_n_i,
	input wire logic meas_done_i,
	input wire logic [PRESS_W-1:0] meas_value_i,
	input wire logic [PRESS_W-1:0] overpressure_setpoint_i,
	output logic tare_active_o,
	output logic tared_status_o,
	output logic overpressure_o
);
	////////////////////////////////////////////////////////////////////////////////
	// Pin synchroniser
	logic tare_n_sync;

	toio_sync u_sync
	(
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.async_i(tare_n_i),
		.sync_o(tare_n_sync)
	);

	////////////////////////////////////////////////////////////////////////////////
	// State
	localparam int CNT_W = $clog2(DEB_CYCLES + 1);

	typedef struct packed
	{
		toio_pkg::toio_key_t key;
		logic [CNT_W-1:0] cnt;
		logic pending;
		logic seen;
		logic taring;
		logic tared;
		logic over;
	} toio_state_t;

	toio_state_t cur_r;
	toio_state_t cur_nxt;

	function automatic logic cnt_done(input logic [CNT_W-1:0] c);
		cnt_done = (c >= CNT_W'(DEB_CYCLES - 1));
	endfunction

	// Debounce: a closure must hold to give one event, then a release must hold before the next;
	// bounce on either edge therefore cannot double-toggle
	always_comb
	begin
		cur_nxt = cur_r;
		case (cur_r.key)
			toio_pkg::TOIO_IDLE:
			begin
				if (!tare_n_sync)
				begin
					if (cnt_done(cur_r.cnt))
					begin
						cur_nxt.key = toio_pkg::TOIO_PRESSED;
						cur_nxt.cnt = '0;
						// Presses before the first measurement are dropped, so taring stays low
						cur_nxt.pending = cur_r.seen ? ~cur_r.pending : cur_r.pending;
					end
					else
					begin
						cur_nxt.cnt = cur_r.cnt + CNT_W'(1);
					end
				end
				else
				begin
					cur_nxt.cnt = '0;
				end
			end
			toio_pkg::TOIO_PRESSED:
			begin
				if (tare_n_sync)
				begin
					cur_nxt.key = toio_pkg::TOIO_RELEASE;
					cur_nxt.cnt = '0;
				end
			end
			toio_pkg::TOIO_RELEASE:
			begin
				if (!tare_n_sync)
				begin
					cur_nxt.key = toio_pkg::TOIO_PRESSED;
				end
				else if (cnt_done(cur_r.cnt))
				begin
					cur_nxt.key = toio_pkg::TOIO_IDLE;
					cur_nxt.cnt = '0;
				end
				else
				begin
					cur_nxt.cnt = cur_r.cnt + CNT_W'(1);
				end
			end
			default:
			begin
				cur_nxt.key = toio_pkg::TOIO_IDLE;
				cur_nxt.cnt = '0;
			end
		endcase

		// Taring state follows the event toggle; pending is a request parity, not a flag
		cur_nxt.taring = cur_nxt.pending;

		// Status outputs update only when a measurement completes, so a toggle
		// shows up on the tare status only with the next measurement
		if (meas_done_i)
		begin
			cur_nxt.seen = 1'b1;
			cur_nxt.tared = cur_r.taring;
			cur_nxt.over = (meas_value_i > overpressure_setpoint_i);
		end
	end

	// All low at reset until the first measurement completes
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cur_r <= '{key: toio_pkg::TOIO_IDLE, cnt: '0, pending: 1'b0, seen: 1'b0,
				taring: 1'b0, tared: 1'b0, over: 1'b0};
		end
		else
		begin
			cur_r <= cur_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs straight from flip-flops
	assign tare_active_o = cur_r.taring;
	assign tared_status_o = cur_r.tared;
	assign overpressure_o = cur_r.over;
endmodule

// file: tb/toio_contact.sv
module toio_contact
(
	input wire logic press_i,
	output logic tare_n_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Closure grounds the line, the pull-up idles it high
	assign tare_n_o = ~press_i;
endmodule

// file: tb/toio_top_assertions.sv
module toio_chk
#(
	parameter int PRESS_W = 32,
	parameter int DEB_CYCLES = 4
)
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic tare_n_i,
	input wire logic meas_done_i,
	input wire logic [PRESS_W-1:0] meas_value_i,
	input wire logic [PRESS_W-1:0] overpressure_setpoint_i,
	input wire logic tare_active_o,
	input wire logic tared_status_o,
	input wire logic overpressure_o
);
	logic seen_r;
	wire gt_w = meas_value_i > overpressure_setpoint_i;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// First measurement since reset
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
		if (!rst_n_i)
			seen_r <= 1'b0;
		else if (meas_done_i)
			seen_r <= 1'b1;
	// The run of 8 relies on the short debounce count
	chk_tare_copy: assert property (meas_done_i |=> tared_status_o == $past(tare_active_o))
		else $error("tare status");
	chk_over_strict: assert property (meas_done_i |=> overpressure_o == $past(gt_w))
		else $error("overpressure");
	chk_status_hold: assert property (!meas_done_i |=> $stable({tared_status_o, overpressure_o}))
		else $error("status moved");
	chk_reset_low: assert property (!seen_r |-> !(tared_status_o | overpressure_o | tare_active_o))
		else $error("not low");
	chk_toggle_cause: assert property ($changed(tare_active_o) |-> !$past(tare_n_i, 5))
		else $error("toggle cause");
	chk_toggle_once: assert property ($changed(tare_active_o) |=> $stable(tare_active_o)[*8])
		else $error("double toggle");
endmodule
bind toio_top toio_chk #(.PRESS_W(PRESS_W), .DEB_CYCLES(DEB_CYCLES)) chk_u (.sys_clk_i(sys_clk_i),
	.rst_n_i(rst_n_i), .tare_n_i(tare_n_i), .meas_done_i(meas_done_i), .meas_value_i(meas_value_i),
	.overpressure_setpoint_i(overpressure_setpoint_i), .tare_active_o(tare_active_o),
	.tared_status_o(tared_status_o), .overpressure_o(overpressure_o));

// file: tb/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst_n = 1'b0, press = 1'b0, done = 1'b0;
	logic [31:0] val = 32'h0, sp = 32'h0;
	logic tare_n, act, tared, over;
	int error_cnt = 0, checked = 0, seed = 32'h1643, tare_m = 0, seen_m = 0;
	always #2 clk = ~clk;
	toio_contact sw_u (.press_i(press), .tare_n_o(tare_n));
	toio_top #(.PRESS_W(32), .DEB_CYCLES(4)) dut_u (.sys_clk_i(clk), .rst_n_i(rst_n),
		.tare_n_i(tare_n), .meas_done_i(done), .meas_value_i(val), .overpressure_setpoint_i(sp),
		.tare_active_o(act), .tared_status_o(tared), .overpressure_o(over));
	task chk(input logic a, input logic b);
		checked++;
		if (a !== b)
		begin
			error_cnt++;
			$display("MISMATCH %0t got %b", $time, a);
		end
	endtask
	task print_verdict;
		if (error_cnt == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// One measurement, checked one cycle after it is taken
	task meas(input logic [31:0] s, input int d);
		@(posedge clk);
		done <= 1'b1;
		sp <= s;
		val <= s + d;
		@(posedge clk);
		done <= 1'b0;
		#1;
		chk(tared, tare_m[0]);
		chk(over, val > sp);
		seen_m = 1;
	endtask
	// Presses shorter than the debounce count must be ignored
	task push(input int n);
		@(posedge clk);
		press <= 1'b1;
		repeat (n) @(posedge clk);
		press <= 1'b0;
		repeat (16) @(posedge clk);
		if (n > 8 && seen_m != 0)
			tare_m = 1 - tare_m;
		chk(act, tare_m[0]);
	endtask
	initial
	begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk(tared | over | act, 1'b0);
		push(12);
		for (int i = 0; i < 30; i++)
		begin
			if (i % 6 == 2)
				push(i % 12 == 2 ? 2 : 12);
			meas($random(seed), i % 3 - 1);
		end
		print_verdict;
	end
endmodule
